// ### hw/tea_translation_enable_ack.sv
// Overview of operation
// - Disabled, no abort: bypass with global attributes
// - Disabled with abort setting: abort transactions
// - Disabled: translation requests get unsupported status
// - Disabled: ignore cache-invalidate, page-response, completions
// - Disabled: page-request queue off, drop requests
// - Disabled: abort translated transactions
// - Disabled: no stream-table fetches, ignore base
// - Disabled: no cache inserts, invalidation still allowed
// - Disabled: no prefetch, table updates, speculative flags
// - Disabled: no translation events, no software translations
// - Command and event queues run independently
// - Enable ack after second control, bypass off, runs clear
// - Disable ack after stalls marked for abort
// - Disable completion releases stall tags
// - Disable ack after software translations finished or faulted
// - After disable, new transactions bypass
// - Each transaction sees one enable value
// - No invalidate on change; other side unaffected
// - Wildcard field encodes 0..4, others exact
// - Check bit: fast zero, safe one
// - Ack exposes queue and translation enable bits
// - Ack mirrors each control field after update
`timescale 1ns/1ps
`default_nettype none

module tea_translation_enable_ack #(
  parameter bit WILDCARD_IMPL = 1'b1,  // Identifier-wildcard field present
  parameter bit CHECK_IMPL    = 1'b1,  // Translated-traffic check present
  parameter bit PAGE_REQ_IMPL = 1'b1,  // Page-request queue present
  parameter int ATTR_W        = 8      // Width of global bypass attributes
) (
  // Clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  // Register port
  input  wire logic                          i_reg_write,
  input  wire logic                          i_reg_read,
  input  wire logic [11:0]                   i_reg_addr,
  input  wire logic [31:0]                   i_reg_wdata,
  output logic [31:0]                        o_reg_rdata,
  output logic                               o_reg_rvalid,
  // Global bypass settings
  input  wire logic                          i_bypass_abort,
  input  wire logic [ATTR_W-1:0]             i_global_bypass_attributes,
  // Incoming transactions
  input  wire logic                          i_txn_valid,
  input  wire logic [tea_pkg::KIND_W-1:0]    i_txn_kind,
  input  wire logic                          i_txn_secure,
  input  wire logic                          i_txn_has_sub_context_index,
  output logic                               o_txn_valid,
  output logic [tea_pkg::ACTION_W-1:0]       o_txn_action,
  output logic [ATTR_W-1:0]                  o_txn_attrs,
  // Enable-transition handshakes with the translation engine
  input  wire logic                          i_second_control_applied,
  input  wire logic                          i_software_translation_running,
  input  wire logic                          i_software_translation_results_written,
  input  wire logic                          i_stalls_marked,
  output logic                               o_mark_stalls_abort,
  output logic                               o_software_translation_terminate,
  output logic                               o_stall_tag_release,
  // Per-field update handshakes
  input  wire logic                          i_command_queue_applied,
  input  wire logic                          i_event_queue_applied,
  input  wire logic                          i_page_request_queue_applied,
  input  wire logic                          i_wildcard_applied,
  input  wire logic                          i_check_applied,
  // Gates for the translation engine
  output logic                               o_translation_active,
  output logic                               o_stream_table_fetch_en,
  output logic                               o_cache_fill_en,
  output logic                               o_cache_invalidate_en,
  output logic                               o_prefetch_en,
  output logic                               o_hardware_table_entry_update_en,
  output logic                               o_access_flag_speculative_en,
  output logic                               o_translation_event_en,
  output logic                               o_software_translation_accept,
  output logic                               o_endpoint_cache_invalidate_command_en,
  output logic                               o_page_response_command_en,
  output logic                               o_stall_allowed,
  // Queue and mode controls
  output logic                               o_command_queue_enable,
  output logic                               o_event_queue_enable,
  output logic                               o_page_request_queue_effective,
  output logic [tea_pkg::WILDCARD_W-1:0]     o_identifier_wildcard,
  output logic                               o_translated_traffic_check
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (ATTR_W < 1 || ATTR_W > 32) begin : g_bad_attr
    $error("ATTR_W must lie between 1 and 32");
  end

  // Reserved wildcard codes behave as exact match
  function automatic logic [2:0] wildcard_decode(input logic [2:0] code);
    wildcard_decode = (code > tea_pkg::WILDCARD_MAX) ? tea_pkg::WILDCARD_EXACT : code;
  endfunction : wildcard_decode

  ////////////////////////////////////////////////////////////////////////
  // Enable sequencer states
  typedef enum logic [2:0] {
    TEA_IDLE,
    TEA_EN_WAIT,
    TEA_DIS_MARK,
    TEA_DIS_TERM,
    TEA_DIS_RELEASE
  } tea_seq_e;

  tea_seq_e    state;            // Sequencer state
  tea_seq_e    next_state;       // Sequencer next state
  logic [31:0] control;          // Written control word, read back with absent and reserved bits cleared
  logic        effective_en;     // Enable value transactions actually see
  logic        next_effective_en;
  logic        ack_en;           // Acknowledged translation enable
  logic        next_ack_en;

  // Mirror outputs
  logic        ack_cmdq;
  logic        ack_evtq;
  logic        ack_priq;
  logic [2:0]  ack_wild;
  logic        ack_check;
  logic        unused_cmdq_req;
  logic        unused_evtq_req;
  logic        unused_priq_req;
  logic        unused_wild_req;
  logic        unused_check_req;
  logic        unused_cmdq_tgt;
  logic        unused_evtq_tgt;
  logic        unused_priq_tgt;
  logic [2:0]  unused_wild_tgt;
  logic        unused_check_tgt;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  wire hit_control = (i_reg_addr == tea_pkg::CONTROL_OFFSET);
  wire hit_ack     = (i_reg_addr == tea_pkg::ACK_OFFSET);
  wire ctrl_write  = i_reg_write && hit_control;

  // Written values per field
  wire       wr_en    = i_reg_wdata[tea_pkg::TRANSLATION_ENABLE_BIT];
  wire       wr_cmdq  = i_reg_wdata[tea_pkg::COMMAND_QUEUE_BIT];
  wire       wr_evtq  = i_reg_wdata[tea_pkg::EVENT_QUEUE_BIT];
  wire       wr_priq  = i_reg_wdata[tea_pkg::PAGE_REQ_QUEUE_BIT] & PAGE_REQ_IMPL;
  wire       wr_check = i_reg_wdata[tea_pkg::TRANSLATED_CHECK_BIT] & CHECK_IMPL;
  wire [2:0] wr_wild  = i_reg_wdata[tea_pkg::WILDCARD_LSB +: tea_pkg::WILDCARD_W] & {3{WILDCARD_IMPL}};

  // Control word keeps only implemented fields
  wire [31:0] ctrl_mask = (32'h1 << tea_pkg::TRANSLATION_ENABLE_BIT)
                        | (32'h1 << tea_pkg::EVENT_QUEUE_BIT)
                        | (32'h1 << tea_pkg::COMMAND_QUEUE_BIT)
                        | ({31'h0, PAGE_REQ_IMPL} << tea_pkg::PAGE_REQ_QUEUE_BIT)
                        | ({31'h0, CHECK_IMPL} << tea_pkg::TRANSLATED_CHECK_BIT)
                        | ({29'h0, {3{WILDCARD_IMPL}}} << tea_pkg::WILDCARD_LSB);

  // Acknowledge word; reserved and absent fields read zero
  wire [31:0] ack_word = ({31'h0, ack_en}    << tea_pkg::TRANSLATION_ENABLE_BIT)
                       | ({31'h0, ack_priq}  << tea_pkg::PAGE_REQ_QUEUE_BIT)
                       | ({31'h0, ack_evtq}  << tea_pkg::EVENT_QUEUE_BIT)
                       | ({31'h0, ack_cmdq}  << tea_pkg::COMMAND_QUEUE_BIT)
                       | ({31'h0, ack_check} << tea_pkg::TRANSLATED_CHECK_BIT)
                       | ({29'h0, ack_wild}  << tea_pkg::WILDCARD_LSB);

  // Unmapped offsets read zero
  wire [31:0] read_mux = hit_control ? control : (hit_ack ? ack_word : 32'h0);

  ////////////////////////////////////////////////////////////////////////
  // Control register; written value is visible before update completes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control <= tea_pkg::CONTROL_RESET;
    end else if (ctrl_write) begin
      control <= i_reg_wdata & ctrl_mask;
    end
  end

  // Read data one cycle after the strobe; reads change no state
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 32'h0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_read;
      o_reg_rdata  <= i_reg_read ? read_mux : o_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mirrors of the independent fields
  tea_field_mirror #(.W(1)) u_cmdq (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_write      (ctrl_write),
    .i_value      (wr_cmdq),
    .i_applied    (i_command_queue_applied),
    .o_update_req (unused_cmdq_req),
    .o_target     (unused_cmdq_tgt),
    .o_ack        (ack_cmdq)
  );

  tea_field_mirror #(.W(1)) u_evtq (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_write      (ctrl_write),
    .i_value      (wr_evtq),
    .i_applied    (i_event_queue_applied),
    .o_update_req (unused_evtq_req),
    .o_target     (unused_evtq_tgt),
    .o_ack        (ack_evtq)
  );

  // Mirror follows the written field, not the effective value
  tea_field_mirror #(.W(1)) u_priq (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_write      (ctrl_write),
    .i_value      (wr_priq),
    .i_applied    (i_page_request_queue_applied),
    .o_update_req (unused_priq_req),
    .o_target     (unused_priq_tgt),
    .o_ack        (ack_priq)
  );

  tea_field_mirror #(.W(3)) u_wild (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_write      (ctrl_write),
    .i_value      (wr_wild),
    .i_applied    (i_wildcard_applied),
    .o_update_req (unused_wild_req),
    .o_target     (unused_wild_tgt),
    .o_ack        (ack_wild)
  );

  tea_field_mirror #(.W(1)) u_check (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_write      (ctrl_write),
    .i_value      (wr_check),
    .i_applied    (i_check_applied),
    .o_update_req (unused_check_req),
    .o_target     (unused_check_tgt),
    .o_ack        (ack_check)
  );

  ////////////////////////////////////////////////////////////////////////
  // Translation enable sequencer
  // A write to the enable while a transition runs is ignored: first value wins
  wire en_change = ctrl_write && (state == TEA_IDLE) && (wr_en != ack_en);

  always_comb begin
    next_state        = state;
    next_effective_en = effective_en;
    next_ack_en       = ack_en;
    case (state)
      TEA_IDLE: begin
        if (en_change && wr_en) begin
          next_state = TEA_EN_WAIT;
        end else if (en_change) begin
          // New transactions bypass and cannot stall from here on
          next_effective_en = 1'b0;
          next_state        = TEA_DIS_MARK;
        end
      end
      TEA_EN_WAIT: begin
        // Second control applied and no software run flag set
        if (i_second_control_applied && !i_software_translation_running) begin
          next_effective_en = 1'b1;
          next_ack_en       = 1'b1;
          next_state        = TEA_IDLE;
        end
      end
      TEA_DIS_MARK: begin
        // Wait until every stalled transaction is marked for abort
        if (i_stalls_marked) begin
          next_state = TEA_DIS_TERM;
        end
      end
      TEA_DIS_TERM: begin
        // Software translations faulted, flags clear, results stored
        if (!i_software_translation_running && i_software_translation_results_written) begin
          next_state = TEA_DIS_RELEASE;
        end
      end
      TEA_DIS_RELEASE: begin
        // Stall tags released in this state; the ack clears one cycle later
        next_ack_en = 1'b0;
        next_state  = TEA_IDLE;
      end
      default: begin
        next_state = TEA_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state        <= TEA_IDLE;
      effective_en <= tea_pkg::BIT_RESET;
      ack_en       <= tea_pkg::BIT_RESET;
    end else begin
      state        <= next_state;
      effective_en <= next_effective_en;
      ack_en       <= next_ack_en;
    end
  end

  // Handshake requests to the translation engine
  assign o_mark_stalls_abort             = (state == TEA_DIS_MARK);
  assign o_software_translation_terminate = (state == TEA_DIS_TERM);
  assign o_stall_tag_release             = (state == TEA_DIS_RELEASE);

  ////////////////////////////////////////////////////////////////////////
  // Gates on table and cache activity; enable flips flush nothing
  assign o_translation_active             = effective_en;
  assign o_stream_table_fetch_en          = effective_en;
  assign o_cache_fill_en                  = effective_en;
  assign o_cache_invalidate_en            = 1'b1;
  assign o_prefetch_en                    = effective_en;
  assign o_hardware_table_entry_update_en = effective_en;
  assign o_access_flag_speculative_en     = effective_en;
  assign o_translation_event_en           = effective_en;
  assign o_software_translation_accept    = effective_en;
  assign o_endpoint_cache_invalidate_command_en = effective_en;
  assign o_page_response_command_en       = effective_en;
  assign o_stall_allowed                  = effective_en;

  // Queue controls follow their own acknowledged fields; page-request queue is also gated by the enable
  assign o_command_queue_enable          = ack_cmdq;
  assign o_event_queue_enable            = ack_evtq;
  assign o_page_request_queue_effective  = ack_priq & effective_en;
  assign o_identifier_wildcard           = wildcard_decode(ack_wild);
  assign o_translated_traffic_check      = ack_check;

  ////////////////////////////////////////////////////////////////////////
  // Transaction decision
  logic [2:0] next_action;  // Decision for the incoming transaction

  // The sub-context index changes nothing while bypassing
  wire unused_sub_ctx = i_txn_has_sub_context_index;

  always_comb begin
    next_action = tea_pkg::ACT_TRANSLATE;
    if (i_txn_secure) begin
      // Other interface's traffic is not judged here
      next_action = tea_pkg::ACT_OTHER_SIDE;
    end else if (effective_en) begin
      next_action = tea_pkg::ACT_TRANSLATE;
    end else begin
      case (i_txn_kind)
        tea_pkg::KIND_ATS_REQUEST:  next_action = tea_pkg::ACT_UNSUPPORTED;
        tea_pkg::KIND_ATS_TRANSL:   next_action = tea_pkg::ACT_ABORT;
        tea_pkg::KIND_PAGE_REQUEST: next_action = tea_pkg::ACT_DISCARD;
        tea_pkg::KIND_INVAL_DONE:   next_action = tea_pkg::ACT_DISCARD;
        default: begin
          // Abort setting chooses between abort and bypass
          next_action = i_bypass_abort ? tea_pkg::ACT_ABORT : tea_pkg::ACT_BYPASS;
        end
      endcase
    end
  end

  // One registered decision per transaction: a single enable sample, in
  // arrival order, so ordering through this stage is preserved
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_txn_valid  <= 1'b0;
      o_txn_action <= tea_pkg::ACT_TRANSLATE;
      o_txn_attrs  <= '0;
    end else begin
      o_txn_valid <= i_txn_valid;
      if (i_txn_valid) begin
        o_txn_action <= next_action;
        o_txn_attrs  <= i_global_bypass_attributes;
      end
    end
  end

endmodule : tea_translation_enable_ack

`default_nettype wire

// ### hw/tea_pkg.sv
package tea_pkg;

  // Register byte offsets on the memory-mapped port
  localparam logic [11:0] CONTROL_OFFSET = 12'h020;
  localparam logic [11:0] ACK_OFFSET     = 12'h024;

  // Field positions shared by the control and acknowledge registers
  localparam int TRANSLATION_ENABLE_BIT = 0;
  localparam int PAGE_REQ_QUEUE_BIT     = 1;
  localparam int EVENT_QUEUE_BIT        = 2;
  localparam int COMMAND_QUEUE_BIT      = 3;
  localparam int TRANSLATED_CHECK_BIT   = 4;
  localparam int WILDCARD_LSB           = 6;
  localparam int WILDCARD_W             = 3;

  // Reset values
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
  localparam logic        BIT_RESET      = 1'h0;
  localparam logic [2:0]  WILDCARD_RESET = 3'h0;

  // Identifier-wildcard codes
  localparam logic [2:0] WILDCARD_EXACT = 3'h0;
  localparam logic [2:0] WILDCARD_MAX   = 3'h4;

  // Translated-traffic check modes
  localparam logic CHECK_FAST = 1'h0;
  localparam logic CHECK_SAFE = 1'h1;

  // Incoming transaction kinds
  localparam int KIND_W = 3;
  localparam logic [2:0] KIND_NORMAL       = 3'h0;
  localparam logic [2:0] KIND_ATS_REQUEST  = 3'h1;
  localparam logic [2:0] KIND_ATS_TRANSL   = 3'h2;
  localparam logic [2:0] KIND_PAGE_REQUEST = 3'h3;
  localparam logic [2:0] KIND_INVAL_DONE   = 3'h4;

  // Decision given to each transaction
  localparam int ACTION_W = 3;
  localparam logic [2:0] ACT_TRANSLATE   = 3'h0;
  localparam logic [2:0] ACT_BYPASS      = 3'h1;
  localparam logic [2:0] ACT_ABORT       = 3'h2;
  localparam logic [2:0] ACT_UNSUPPORTED = 3'h3;
  localparam logic [2:0] ACT_DISCARD     = 3'h4;
  localparam logic [2:0] ACT_OTHER_SIDE  = 3'h5;

endpackage : tea_pkg

// ### hw/tea_field_mirror.sv
`timescale 1ns/1ps
`default_nettype none

// One acknowledge mirror: latches a new control value, asks the consumer
// to apply it and copies it into the acknowledge field once applied.
module tea_field_mirror #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Control field side
  input  wire logic         i_write,
  input  wire logic [W-1:0] i_value,
  // Consumer handshake
  input  wire logic         i_applied,
  output logic              o_update_req,
  output logic [W-1:0]      o_target,
  // Acknowledge field
  output logic [W-1:0]      o_ack
);

  logic pending;  // Update in progress

  // A change while pending is ignored: the first value completes
  wire start = i_write && !pending && (i_value != o_ack);

  assign o_update_req = pending;

  ////////////////////////////////////////////////////////////////////////
  // Update tracking
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pending  <= 1'b0;
      o_target <= '0;
      o_ack    <= '0;
    end else if (start) begin
      pending  <= 1'b1;
      o_target <= i_value;
    end else if (pending && i_applied) begin
      // Mirror takes the written value on completion
      pending <= 1'b0;
      o_ack   <= o_target;
    end
  end

endmodule : tea_field_mirror

`default_nettype wire

// ### dv/tea_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// Engine stand-in: applies updates on a slow beat
module tea_engine_model #(
  parameter int DLY = 3  // Cycles between apply pulses
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // Requests from the block
  input  wire logic i_mark,
  input  wire logic i_term,
  input  wire logic i_active,
  // Answers to the block
  output logic      o_applied,
  output logic      o_stalls_marked,
  output logic      o_running,
  output logic      o_written
);
  logic [3:0] tick;  // Apply pacing
  // Running job only while enabled; it ends when told to terminate
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick            <= 4'h0;
      o_applied       <= 1'b0;
      o_stalls_marked <= 1'b0;
      o_running       <= 1'b0;
      o_written       <= 1'b0;
    end else begin
      tick            <= (tick == 4'(DLY)) ? 4'h0 : tick + 4'h1;
      o_applied       <= (tick == 4'(DLY));
      o_stalls_marked <= i_mark;
      o_running       <= i_active && !i_term;
      o_written       <= i_term;
    end
  end
endmodule : tea_engine_model
`default_nettype wire

// ### dv/tea_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks; one clock domain, so default clocking
module tea_checker (
  input wire logic       i_clock, i_rst_n, i_reg_read, o_reg_rvalid, i_bypass_abort,
  input wire logic       i_txn_valid, i_txn_secure, o_txn_valid, o_translation_active,
  input wire logic [2:0] i_txn_kind, o_txn_action, o_identifier_wildcard,
  input wire logic       i_second_control_applied, i_software_translation_running,
  input wire logic       o_mark_stalls_abort, o_stall_tag_release, o_stall_allowed,
  input wire logic       o_stream_table_fetch_en, o_cache_fill_en, o_cache_invalidate_en,
  input wire logic       o_prefetch_en, o_translation_event_en, o_page_request_queue_effective
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire logic off_ns = i_txn_valid && !i_txn_secure && !o_translation_active;  // Disabled path
  a_bypass_when_off: assert property (off_ns && i_txn_kind == tea_pkg::KIND_NORMAL && !i_bypass_abort
    |=> o_txn_valid && o_txn_action == tea_pkg::ACT_BYPASS) else $error("bypass missing");
  a_abort_when_off: assert property (off_ns && i_txn_kind == tea_pkg::KIND_NORMAL && i_bypass_abort
    |=> o_txn_action == tea_pkg::ACT_ABORT) else $error("abort missing");
  a_ats_unsupported: assert property (off_ns && i_txn_kind == tea_pkg::KIND_ATS_REQUEST
    |=> o_txn_action == tea_pkg::ACT_UNSUPPORTED) else $error("request not refused");
  a_page_discard: assert property (off_ns && i_txn_kind == tea_pkg::KIND_PAGE_REQUEST
    |=> o_txn_action == tea_pkg::ACT_DISCARD) else $error("page request kept");
  a_translated_abort: assert property (off_ns && i_txn_kind == tea_pkg::KIND_ATS_TRANSL
    |=> o_txn_action == tea_pkg::ACT_ABORT) else $error("translated not aborted");
  a_other_side: assert property (i_txn_valid && i_txn_secure
    |=> o_txn_valid && o_txn_action == tea_pkg::ACT_OTHER_SIDE) else $error("other side touched");
  a_gates_off: assert property (!o_translation_active |-> o_cache_invalidate_en
    && !(o_stream_table_fetch_en || o_cache_fill_en || o_prefetch_en || o_translation_event_en
    || o_page_request_queue_effective)) else $error("gate open while disabled");
  a_enable_ack: assert property ($rose(o_translation_active)
    |-> $past(i_second_control_applied) && !$past(i_software_translation_running)) else $error("early enable");
  a_mark_blocks: assert property (o_mark_stalls_abort |-> !o_stall_allowed && !o_translation_active)
    else $error("stall allowed");
  a_release_pulse: assert property (o_stall_tag_release |=> !o_stall_tag_release) else $error("long release");
  a_read_answer: assert property (i_reg_read |=> o_reg_rvalid) else $error("read unanswered");
  a_wildcard_range: assert property (o_identifier_wildcard <= tea_pkg::WILDCARD_MAX) else $error("bad code");
endmodule : tea_checker
bind tea_translation_enable_ack tea_checker u_chk (.i_clock, .i_rst_n, .i_reg_read, .o_reg_rvalid,
  .i_bypass_abort, .i_txn_valid, .i_txn_secure, .o_txn_valid, .o_translation_active, .i_txn_kind,
  .o_txn_action, .o_identifier_wildcard, .i_second_control_applied, .i_software_translation_running,
  .o_mark_stalls_abort, .o_stall_tag_release, .o_stall_allowed, .o_stream_table_fetch_en, .o_cache_fill_en,
  .o_cache_invalidate_en, .o_prefetch_en, .o_translation_event_en, .o_page_request_queue_effective);
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clock = 1'b0, i_rst_n = 1'b0, wr = 1'b0, rd = 1'b0, abt = 1'b0, tv = 1'b0, ts = 1'b0, sub = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0000_0000, r;
  logic [2:0]  tk = 3'h0;
  logic [7:0]  attr = 8'h5a;  // Bypass attributes under test
  int          err_total = 0, n_compared = 0, rel_n = 0;
  wire logic [31:0] rdat;
  wire logic [7:0]  tatt;
  wire logic [2:0]  tact, wcode;
  wire logic        ap, sm, run, wrt, mark, term, rel, act, cq, pq, chkb;
  always #2.5 i_clock = ~i_clock;  // 200 MHz
  tea_translation_enable_ack dut (.i_clock, .i_rst_n, .i_reg_write(wr), .i_reg_read(rd), .i_reg_addr(adr),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(), .i_bypass_abort(abt), .i_global_bypass_attributes(attr),
    .i_txn_valid(tv), .i_txn_kind(tk), .i_txn_secure(ts), .i_txn_has_sub_context_index(sub), .o_txn_valid(),
    .o_txn_action(tact), .o_txn_attrs(tatt), .i_second_control_applied(ap), .i_software_translation_running(run),
    .i_software_translation_results_written(wrt), .i_stalls_marked(sm), .o_mark_stalls_abort(mark),
    .o_software_translation_terminate(term), .o_stall_tag_release(rel), .i_command_queue_applied(ap),
    .i_event_queue_applied(ap), .i_page_request_queue_applied(ap), .i_wildcard_applied(ap), .i_check_applied(ap),
    .o_translation_active(act), .o_stream_table_fetch_en(), .o_cache_fill_en(), .o_cache_invalidate_en(),
    .o_prefetch_en(), .o_hardware_table_entry_update_en(), .o_access_flag_speculative_en(),
    .o_translation_event_en(), .o_software_translation_accept(), .o_endpoint_cache_invalidate_command_en(),
    .o_page_response_command_en(), .o_stall_allowed(), .o_command_queue_enable(cq), .o_event_queue_enable(),
    .o_page_request_queue_effective(pq), .o_identifier_wildcard(wcode), .o_translated_traffic_check(chkb));
  tea_engine_model eng (.i_clock, .i_rst_n, .i_mark(mark), .i_term(term), .i_active(act), .o_applied(ap),
    .o_stalls_marked(sm), .o_running(run), .o_written(wrt));
  always @(posedge i_clock) if (rel) rel_n++;  // Tag releases seen
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge i_clock); wr = 1'b1; adr = a; wd = d;
    @(negedge i_clock); wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [11:0] a);
    @(negedge i_clock); rd = 1'b1; adr = a;
    @(negedge i_clock); rd = 1'b0; r = rdat;
  endtask : reg_rd
  // Software polls the mirror, bounded; always one fresh read first
  task automatic poll_ack(input logic [31:0] e);
    for (int i = 0; i < 40 && (i == 0 || r !== e); i++) reg_rd(tea_pkg::ACK_OFFSET);
    chk("ack", e, r);
  endtask : poll_ack
  task automatic txn(input logic [2:0] k, input logic s, input logic [2:0] e);
    @(negedge i_clock); tv = 1'b1; tk = k; ts = s;
    @(negedge i_clock); tv = 1'b0;
    chk("action", {29'h0, e}, {29'h0, tact});
  endtask : txn
  task automatic t_reset;
    reg_rd(tea_pkg::ACK_OFFSET); chk("ack reset", 32'h0, r);
    reg_rd(12'h100); chk("unmapped", 32'h0, r);
  endtask : t_reset
  task automatic t_disabled;
    sub = 1'b1;
    txn(tea_pkg::KIND_NORMAL, 1'b0, tea_pkg::ACT_BYPASS); chk("attrs", {24'h0, attr}, {24'h0, tatt});
    txn(tea_pkg::KIND_ATS_REQUEST, 1'b0, tea_pkg::ACT_UNSUPPORTED);
    txn(tea_pkg::KIND_ATS_TRANSL, 1'b0, tea_pkg::ACT_ABORT);
    txn(tea_pkg::KIND_PAGE_REQUEST, 1'b0, tea_pkg::ACT_DISCARD);
    txn(tea_pkg::KIND_INVAL_DONE, 1'b0, tea_pkg::ACT_DISCARD);
    txn(tea_pkg::KIND_NORMAL, 1'b1, tea_pkg::ACT_OTHER_SIDE);
    abt = 1'b1;
    txn(tea_pkg::KIND_NORMAL, 1'b0, tea_pkg::ACT_ABORT);
    abt = 1'b0;
  endtask : t_disabled
  task automatic t_enable;
    reg_wr(tea_pkg::CONTROL_OFFSET, 32'h0000_011f);
    reg_rd(tea_pkg::CONTROL_OFFSET); chk("control", 32'h0000_011f, r);
    poll_ack(32'h0000_011f);
    chk("wildcard", 32'h4, {29'h0, wcode});
    chk("prq on", 32'h1, {31'h0, pq});
    chk("check bit", 32'h1, {31'h0, chkb});
    txn(tea_pkg::KIND_NORMAL, 1'b0, tea_pkg::ACT_TRANSLATE);
  endtask : t_enable
  task automatic t_disable;
    reg_wr(tea_pkg::CONTROL_OFFSET, 32'h0000_000e);
    poll_ack(32'h0000_000e);
    chk("releases", 32'h1, 32'(rel_n));
    chk("cmdq kept", 32'h1, {31'h0, cq});
    chk("prq off", 32'h0, {31'h0, pq});
    txn(tea_pkg::KIND_NORMAL, 1'b0, tea_pkg::ACT_BYPASS);
  endtask : t_disable
  task automatic t_reserved_code;
    reg_wr(tea_pkg::CONTROL_OFFSET, 32'h0000_01c0);
    poll_ack(32'h0000_01c0);
    chk("reserved code", 32'h0, {29'h0, wcode});
  endtask : t_reserved_code
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (10) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_reset(); t_disabled(); t_enable(); t_disable(); t_reserved_code();
    finish_test();
  end
  initial begin
    #40000;
    err_total++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
